// >>> pkg/mmps_pkg.sv
// Purpose: constants for the mains monitor and protection sequencer
// Assumes: 40 MHz clock
// Notes: times kept in their own units, cycle counts derived
package mmps_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BROWNOUT_MS = 30;
  localparam int unsigned HOLD_MS = 6;
  localparam int unsigned HOLD_BURST_MS = 97;
  localparam int unsigned NOMAINS_MS = 28;
  localparam int unsigned OTP_INT_NS = 4500;
  localparam int unsigned OTP_INT_CYC = (OTP_INT_NS * 40 + 999) / 1000;
  localparam int unsigned PROT_FILT_MS = 2;
  localparam int unsigned ONTIME_US = 55;
  localparam int unsigned ONTIME_CYC = ONTIME_US * 40;
  localparam int unsigned OPP_RUN_MS = 200;
  localparam int unsigned OPP_START_MS = 40;
  localparam int unsigned OVP_PULSES = 4;
  localparam int unsigned RESTART_MS = 100;
  localparam logic [1:0] MODE_QR = 2'h0;
  localparam logic [1:0] MODE_DCM = 2'h1;
  localparam logic [1:0] MODE_FR = 2'h2;
  localparam logic [1:0] MODE_BURST = 2'h3;
  typedef enum logic [4:0] {
    ST_OFF = 5'b0_0001,
    ST_WAIT = 5'b0_0010,
    ST_RUN = 5'b0_0100,
    ST_RESTART = 5'b0_1000,
    ST_HALT = 5'b1_0000
  } mmps_state_e;
endpackage : mmps_pkg

// >>> src/mmps_sequencer.sv
// Purpose: start-up, mains monitoring, mode select and protection sequencing
// Assumes: all inputs synchronous to clk_in, comparator results as levels
// Notes: analog loops are outside; this block only decides and gates
`timescale 1ns/1ps
module mmps_sequencer #(
  parameter int unsigned TICK_CYCLES = mmps_pkg::TICK_CYC,
  parameter int unsigned RESTART_TICKS = mmps_pkg::RESTART_MS
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // mains sampling
  input wire logic above_brownin_in,
  input wire logic above_brownout_in,
  input wire logic above_mains_high_in,
  output logic mains_sense_pin_sink_out,
  output logic mains_sense_pin_charge_out,
  // supplies
  input wire logic lower_supply_pin_at_start_in,
  input wire logic lower_supply_pin_low_in,
  input wire logic lower_supply_pin_undervoltage_lockout_in,
  output logic circuits_enable_out,
  output logic upper_supply_pin_reg_out,
  output logic lower_supply_pin_dch_out,
  // control and power
  input wire logic protect_ok_in,
  input wire logic protect_det_in,
  input wire logic power_max_in,
  input wire logic in_regulation_in,
  input wire logic max_freq_in,
  input wire logic medium_power_in,
  input wire logic low_power_in,
  // switching events
  input wire logic gate_req_in,
  input wire logic demag_in,
  input wire logic valley_in,
  // faults
  input wire logic aux_open_in,
  input wire logic otp_int_in,
  input wire logic ovp_aux_in,
  input wire logic ovp_lower_supply_pin_in,
  input wire logic overpower_in,
  // outputs
  output logic gate_out,
  output logic soft_start_out,
  output logic [1:0] mode_out,
  output logic mains_present_out,
  output logic brownout_out
);
  mmps_pkg::mmps_state_e state_r;
  logic [15:0] tick_cnt_r;
  logic tick;
  logic sampling;
  logic [6:0] hold_cnt_r;
  logic prev_bi_r, prev_hi_r, slope;
  logic [4:0] noslope_cnt_r;
  logic [4:0] bo_cnt_r;
  logic bi_seen_r;
  logic [7:0] otp_cnt_r;
  logic [2:0] filt_cnt_r;
  logic [2:0] ovp_cnt_r;
  logic [7:0] opp_cnt_r;
  logic [11:0] on_cnt_r;
  logic [15:0] rst_cnt_r;
  logic started_r;
  logic armed_r;
  logic gate_prev_r, gate_rise;
  logic fault_restart, brownout_hit, ontime_hit, opp_hit;

  // --------------------------------------------------------------
  // 1 ms tick and sampling
  // --------------------------------------------------------------
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) tick_cnt_r <= 16'h0000;
    else if (clk_en_in) tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end
  assign sampling = tick && (hold_cnt_r == 7'h00);
  assign slope = sampling && ((above_brownin_in && !prev_bi_r) ||
                              (above_mains_high_in && !prev_hi_r));
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prev_bi_r <= 1'b0;
      prev_hi_r <= 1'b0;
      bi_seen_r <= 1'b0;
    end else if (clk_en_in && sampling) begin
      prev_bi_r <= above_brownin_in;
      prev_hi_r <= above_mains_high_in;
      bi_seen_r <= above_brownin_in;
    end
  end
  // sampling suspension after mains detected
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) hold_cnt_r <= 7'h00;
    else if (clk_en_in) begin
      if (slope)
        hold_cnt_r <= (mode_out == mmps_pkg::MODE_BURST) ?
                      7'(mmps_pkg::HOLD_BURST_MS) : 7'(mmps_pkg::HOLD_MS);
      else if (tick && hold_cnt_r != 7'h00) hold_cnt_r <= hold_cnt_r - 7'h01;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) noslope_cnt_r <= 5'h00;
    else if (clk_en_in) begin
      if (slope) noslope_cnt_r <= 5'h00;
      else if (tick && noslope_cnt_r != 5'(mmps_pkg::NOMAINS_MS))
        noslope_cnt_r <= noslope_cnt_r + 5'h01;
    end
  end
  assign mains_present_out = (noslope_cnt_r != 5'(mmps_pkg::NOMAINS_MS));
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) mains_sense_pin_sink_out <= 1'b0;
    else if (clk_en_in) mains_sense_pin_sink_out <= sampling || !mains_present_out;
  end

  // --------------------------------------------------------------
  // brownout
  // --------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) bo_cnt_r <= 5'h00;
    else if (clk_en_in) begin
      if (state_r != mmps_pkg::ST_RUN || (sampling && above_brownout_in))
        bo_cnt_r <= 5'h00;
      else if (tick && bo_cnt_r != 5'(mmps_pkg::BROWNOUT_MS))
        bo_cnt_r <= bo_cnt_r + 5'h01;
    end
  end
  assign brownout_hit = (bo_cnt_r == 5'(mmps_pkg::BROWNOUT_MS));
  assign brownout_out = brownout_hit;

  // --------------------------------------------------------------
  // protection qualification
  // --------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    gate_prev_r <= reset_n_in ? (clk_en_in ? gate_out : gate_prev_r) : 1'b0;
  end
  assign gate_rise = gate_out && !gate_prev_r;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) otp_cnt_r <= 8'h00;
    else if (clk_en_in) otp_cnt_r <= !otp_int_in ? 8'h00 :
      (otp_cnt_r == 8'(mmps_pkg::OTP_INT_CYC) ? otp_cnt_r : otp_cnt_r + 8'h01);
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) filt_cnt_r <= 3'h0;
    else if (clk_en_in) begin
      if (protect_det_in) filt_cnt_r <= 3'h0;
      else if (tick && filt_cnt_r != 3'(mmps_pkg::PROT_FILT_MS + 1))
        filt_cnt_r <= filt_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) ovp_cnt_r <= 3'h0;
    else if (clk_en_in) begin
      if (!(ovp_aux_in || ovp_lower_supply_pin_in)) ovp_cnt_r <= 3'h0;
      else if ((protect_det_in ? gate_rise : tick) &&
               ovp_cnt_r != 3'(mmps_pkg::OVP_PULSES)) ovp_cnt_r <= ovp_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) opp_cnt_r <= 8'h00;
    else if (clk_en_in) begin
      if (!overpower_in || state_r != mmps_pkg::ST_RUN) opp_cnt_r <= 8'h00;
      else if (tick && !opp_hit) opp_cnt_r <= opp_cnt_r + 8'h01;
    end
  end
  assign opp_hit = opp_cnt_r >= (started_r ? 8'(mmps_pkg::OPP_START_MS)
                                          : 8'(mmps_pkg::OPP_RUN_MS));
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) on_cnt_r <= 12'h000;
    else if (clk_en_in) on_cnt_r <= !gate_out ? 12'h000 :
      (ontime_hit ? on_cnt_r : on_cnt_r + 12'h001);
  end
  assign ontime_hit = (on_cnt_r == 12'(mmps_pkg::ONTIME_CYC));
  assign fault_restart = (otp_cnt_r == 8'(mmps_pkg::OTP_INT_CYC)) ||
    (filt_cnt_r == 3'(mmps_pkg::PROT_FILT_MS + 1)) ||
    (ovp_cnt_r == 3'(mmps_pkg::OVP_PULSES)) || opp_hit || ontime_hit ||
    (overpower_in && lower_supply_pin_undervoltage_lockout_in);

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) state_r <= mmps_pkg::ST_OFF;
    else if (clk_en_in) begin
      case (state_r)
        mmps_pkg::ST_OFF:
          if (lower_supply_pin_at_start_in) state_r <= mmps_pkg::ST_WAIT;
        mmps_pkg::ST_WAIT:
          if (aux_open_in) state_r <= mmps_pkg::ST_HALT;
          else if (protect_ok_in && bi_seen_r && power_max_in)
            state_r <= mmps_pkg::ST_RUN;
        mmps_pkg::ST_RUN:
          if (aux_open_in) state_r <= mmps_pkg::ST_HALT;
          else if (fault_restart) state_r <= mmps_pkg::ST_RESTART;
          else if (brownout_hit || lower_supply_pin_undervoltage_lockout_in)
            state_r <= mmps_pkg::ST_WAIT;
        mmps_pkg::ST_RESTART:
          if (rst_cnt_r == 16'(RESTART_TICKS)) state_r <= mmps_pkg::ST_WAIT;
        mmps_pkg::ST_HALT:
          if (!aux_open_in) state_r <= mmps_pkg::ST_OFF;
        default: state_r <= mmps_pkg::ST_OFF;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) rst_cnt_r <= 16'h0000;
    else if (clk_en_in) begin
      if (state_r != mmps_pkg::ST_RESTART) rst_cnt_r <= 16'h0000;
      else if (tick && rst_cnt_r != 16'(RESTART_TICKS)) rst_cnt_r <= rst_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) started_r <= 1'b1;
    else if (clk_en_in) begin
      if (state_r != mmps_pkg::ST_RUN) started_r <= 1'b1;
      else if (in_regulation_in) started_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // supplies and mode
  // --------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      circuits_enable_out <= 1'b0;
      mains_sense_pin_charge_out <= 1'b0;
      upper_supply_pin_reg_out <= 1'b0;
      lower_supply_pin_dch_out <= 1'b0;
      soft_start_out <= 1'b0;
      mode_out <= mmps_pkg::MODE_QR;
    end else if (clk_en_in) begin
      circuits_enable_out <= (state_r != mmps_pkg::ST_OFF);
      mains_sense_pin_charge_out <= (state_r == mmps_pkg::ST_WAIT) ||
        (state_r == mmps_pkg::ST_RESTART) ||
        (state_r == mmps_pkg::ST_RUN && started_r);
      upper_supply_pin_reg_out <= lower_supply_pin_low_in;
      lower_supply_pin_dch_out <= (state_r == mmps_pkg::ST_RESTART);
      soft_start_out <= (state_r == mmps_pkg::ST_RUN) && started_r;
      if (low_power_in) mode_out <= mmps_pkg::MODE_BURST;
      else if (medium_power_in) mode_out <= mmps_pkg::MODE_FR;
      else if (max_freq_in) mode_out <= mmps_pkg::MODE_DCM;
      else mode_out <= mmps_pkg::MODE_QR;
    end
  end

  // --------------------------------------------------------------
  // gate drive
  // --------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) armed_r <= 1'b0;
    else if (clk_en_in) begin
      if (gate_out) armed_r <= 1'b0;
      else if (demag_in && valley_in) armed_r <= 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) gate_out <= 1'b0;
    else if (clk_en_in) begin
      if (state_r != mmps_pkg::ST_RUN || fault_restart || aux_open_in)
        gate_out <= 1'b0;
      else if (gate_out) gate_out <= gate_req_in;
      else gate_out <= gate_req_in && armed_r;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_gate_stop;
    @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && state_r != mmps_pkg::ST_RUN) |=> !gate_out;
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("gate on outside run");
  property p_start;
    @(posedge clk_in) disable iff (!reset_n_in)
      ($rose(state_r == mmps_pkg::ST_RUN)) |-> $past(bi_seen_r) && $past(protect_ok_in);
  endproperty
  a_start: assert property (p_start) else $error("start without qualification");
  property p_aux;
    @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && aux_open_in && state_r == mmps_pkg::ST_RUN) |=> state_r == mmps_pkg::ST_HALT;
  endproperty
  a_aux: assert property (p_aux) else $error("aux open not halted");
  property p_ontime;
    @(posedge clk_in) disable iff (!reset_n_in)
      on_cnt_r <= 12'(mmps_pkg::ONTIME_CYC);
  endproperty
  a_ontime: assert property (p_ontime) else $error("on-time overrun");
  property p_disch;
    @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && !mains_present_out) |=> mains_sense_pin_sink_out;
  endproperty
  a_disch: assert property (p_disch) else $error("no discharge");
  property p_vreg;
    @(posedge clk_in) disable iff (!reset_n_in)
      clk_en_in |=> upper_supply_pin_reg_out == $past(lower_supply_pin_low_in);
  endproperty
  a_vreg: assert property (p_vreg) else $error("regulator enable wrong");
  property p_ovp;
    @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && !ovp_aux_in && !ovp_lower_supply_pin_in) |=> ovp_cnt_r == 3'h0;
  endproperty
  a_ovp: assert property (p_ovp) else $error("ovp count not cleared");
  property p_mode;
    @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && low_power_in) |=> mode_out == mmps_pkg::MODE_BURST;
  endproperty
  a_mode: assert property (p_mode) else $error("burst not selected");
endmodule : mmps_sequencer

// >>> testbench/mmps_stage_model.sv
// Purpose: flyback stage seen from the gate output
// Assumes: demagnetization ends a few cycles after the gate falls
// Notes: demag and valley held until the next gate pulse
`timescale 1ns/1ps
module mmps_stage_model (
  // clock
  input wire logic clk_in,
  // gate from the sequencer
  input wire logic gate_in,
  // aux winding events
  output logic demag_out,
  output logic valley_out
);
  logic [2:0] cnt_r = 3'h4;
  logic demag_r = 1'b1;
  logic valley_r = 1'b1;
  assign demag_out = demag_r;
  assign valley_out = valley_r;
  // demag then valley after each pulse
  always @(posedge clk_in) begin
    if (gate_in) begin
      cnt_r <= 3'h0;
      demag_r <= 1'b0;
      valley_r <= 1'b0;
    end else if (cnt_r < 3'h4) begin
      cnt_r <= cnt_r + 3'h1;
    end else begin
      demag_r <= 1'b1;
      valley_r <= demag_r;
    end
  end
endmodule : mmps_stage_model

// >>> testbench/mmps_sequencer_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: 20-cycle tick, 3-tick restart delay
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/1ps
module mmps_sequencer_tb;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic bi = 1'b0, bo = 1'b0, mh = 1'b0, at_st = 1'b0, v_low = 1'b0, undervoltage_lockout = 1'b0;
  logic p_ok = 1'b0, p_det = 1'b1, p_max = 1'b0, in_reg = 1'b0;
  logic mfq = 1'b0, med = 1'b0, lowp = 1'b0, greq = 1'b0, aux_open = 1'b0;
  logic otp = 1'b0, ovpa = 1'b0, ovpc = 1'b0, opp = 1'b0;
  logic demag, valley, sink, charge, cen, ureg, dch, gate, ss, mp, bout;
  logic [1:0] mode;
  int num_errors = 0;
  int check_count = 0;
  int t0;
  always #12.5 clk_in = ~clk_in;
  mmps_sequencer #(.TICK_CYCLES(20), .RESTART_TICKS(3)) mmps_sequencer_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
    .above_brownin_in(bi), .above_brownout_in(bo), .above_mains_high_in(mh),
    .mains_sense_pin_sink_out(sink), .mains_sense_pin_charge_out(charge),
    .lower_supply_pin_at_start_in(at_st), .lower_supply_pin_low_in(v_low),
    .lower_supply_pin_undervoltage_lockout_in(undervoltage_lockout), .circuits_enable_out(cen),
    .upper_supply_pin_reg_out(ureg), .lower_supply_pin_dch_out(dch),
    .protect_ok_in(p_ok), .protect_det_in(p_det), .power_max_in(p_max),
    .in_regulation_in(in_reg), .max_freq_in(mfq), .medium_power_in(med),
    .low_power_in(lowp), .gate_req_in(greq), .demag_in(demag), .valley_in(valley),
    .aux_open_in(aux_open), .otp_int_in(otp), .ovp_aux_in(ovpa), .ovp_lower_supply_pin_in(ovpc),
    .overpower_in(opp), .gate_out(gate), .soft_start_out(ss), .mode_out(mode),
    .mains_present_out(mp), .brownout_out(bout));
  mmps_stage_model mmps_stage_model_i (
    .clk_in(clk_in), .gate_in(gate), .demag_out(demag), .valley_out(valley));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : cyc
  task chk(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic sig(input int s);
    case (s)
      0: return cen;
      1: return ss;
      2: return gate;
      3: return dch;
      5: return mp;
      default: return bout;
    endcase
  endfunction : sig
  task wait_for(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig(s) !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, sig(s), lvl);
      summarize();
    end
  endtask : wait_for
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_startup;
    int pulses;
    chk(gate, 1'b0);
    chk(mode, 2'h0);
    chk(mp, 1'b1);
    cyc(30);
    chk(cen, 1'b0);
    at_st = 1'b1;
    wait_for(0, 1'b1, 5);
    cyc(2);
    chk(charge, 1'b1);
    p_ok = 1'b1;
    p_max = 1'b1;
    pulses = 0;
    repeat (80) begin
      cyc(1);
      if (sink === 1'b1) pulses++;
    end
    chk(pulses == 4, 1'b1);
    chk(ss, 1'b0);
    bi = 1'b1;
    bo = 1'b1;
    wait_for(1, 1'b1, 100);
    chk(charge, 1'b1);
  endtask : t_startup
  task t_modes;
    mfq = 1'b1;
    cyc(3);
    chk(mode, 2'h1);
    mfq = 1'b0;
    med = 1'b1;
    cyc(3);
    chk(mode, 2'h2);
    med = 1'b0;
    lowp = 1'b1;
    cyc(3);
    chk(mode, 2'h3);
    lowp = 1'b0;
    cyc(3);
    chk(mode, 2'h0);
  endtask : t_modes
  task t_ontime;
    greq = 1'b1;
    cyc(3);
    chk(gate, 1'b1);
    t0 = $time / 25;
    wait_for(2, 1'b0, 2300);
    chk(($time / 25 - t0) >= 2190, 1'b1);
    greq = 1'b0;
    cyc(3);
    chk(dch, 1'b1);
    chk(gate, 1'b0);
    wait_for(3, 1'b0, 200);
    wait_for(1, 1'b1, 400);
  endtask : t_ontime
  task t_supply;
    v_low = 1'b1;
    cyc(2);
    chk(ureg, 1'b1);
    v_low = 1'b0;
    cyc(2);
    chk(ureg, 1'b0);
  endtask : t_supply
  task t_mains;
    int pulses;
    chk(mp, 1'b0);
    chk(sink, 1'b1);
    mh = 1'b1;
    wait_for(5, 1'b1, 25);
    pulses = 0;
    repeat (130) begin
      cyc(1);
      if (sink === 1'b1) pulses++;
    end
    chk(pulses == 0, 1'b1);
    repeat (20) begin
      cyc(1);
      if (sink === 1'b1) pulses++;
    end
    chk(pulses == 1, 1'b1);
    mh = 1'b0;
  endtask : t_mains
  task t_protect;
    otp = 1'b1;
    cyc(150);
    chk(dch, 1'b0);
    otp = 1'b0;
    cyc(1);
    otp = 1'b1;
    t0 = $time / 25;
    wait_for(3, 1'b1, 200);
    chk(($time / 25 - t0) >= 180, 1'b1);
    chk(charge, 1'b1);
    otp = 1'b0;
    wait_for(1, 1'b1, 200);
    p_det = 1'b0;
    p_ok = 1'b0;
    t0 = $time / 25;
    wait_for(3, 1'b1, 80);
    chk(($time / 25 - t0) >= 40, 1'b1);
    cyc(100);
    chk(ss, 1'b0);
    p_det = 1'b1;
    p_ok = 1'b1;
    wait_for(1, 1'b1, 100);
  endtask : t_protect
  task t_ovp;
    ovpa = 1'b1;
    repeat (4) begin
      chk(dch, 1'b0);
      greq = 1'b1;
      cyc(2);
      greq = 1'b0;
      cyc(10);
    end
    chk(dch, 1'b1);
    ovpa = 1'b0;
    wait_for(1, 1'b1, 200);
  endtask : t_ovp
  task t_opp;
    opp = 1'b1;
    t0 = $time / 25;
    wait_for(3, 1'b1, 900);
    chk(($time / 25 - t0) >= 780, 1'b1);
    opp = 1'b0;
    wait_for(1, 1'b1, 200);
    in_reg = 1'b1;
    cyc(3);
    chk(charge, 1'b0);
    chk(ss, 1'b0);
    opp = 1'b1;
    t0 = $time / 25;
    wait_for(3, 1'b1, 4100);
    chk(($time / 25 - t0) >= 3980, 1'b1);
    opp = 1'b0;
    in_reg = 1'b0;
    wait_for(1, 1'b1, 200);
  endtask : t_opp
  task t_aux_open;
    aux_open = 1'b1;
    cyc(3);
    chk(ss, 1'b0);
    chk(charge, 1'b0);
    cyc(100);
    chk(ss, 1'b0);
    aux_open = 1'b0;
    wait_for(1, 1'b1, 400);
  endtask : t_aux_open
  task t_brownout;
    bi = 1'b0;
    bo = 1'b0;
    cyc(400);
    chk(bout, 1'b0);
    wait_for(4, 1'b1, 400);
    cyc(3);
    chk(ss, 1'b0);
    chk(charge, 1'b1);
  endtask : t_brownout
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(10);
    reset_n_in = 1'b1;
    cyc(1);
    t_startup();
    t_modes();
    t_ontime();
    t_supply();
    t_mains();
    t_protect();
    t_ovp();
    t_opp();
    t_aux_open();
    t_brownout();
    summarize();
  end
endmodule : mmps_sequencer_tb
